/* core/stc_pkg.sv */
// Constants for the sixteen-bit timer/counter: register map, field layout,
// reset values, fixed counts and clock select codes.
// Assumes a 32-bit APB slave, one aligned word per byte register.
package stc_pkg;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_CNT_LO = 8'h08;
  localparam logic [7:0] OFS_CNT_HI = 8'h0c;
  localparam logic [7:0] OFS_CMPA_LO = 8'h10;
  localparam logic [7:0] OFS_CMPA_HI = 8'h14;
  localparam logic [7:0] OFS_CMPB_LO = 8'h18;
  localparam logic [7:0] OFS_CMPB_HI = 8'h1c;
  localparam logic [7:0] OFS_CAP_LO = 8'h20;
  localparam logic [7:0] OFS_CAP_HI = 8'h24;
  localparam logic [7:0] OFS_FLAG = 8'h28;
  localparam logic [7:0] OFS_MASK = 8'h2c;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CA_MODE_A = 6;   // bits 7:6 output action A
  localparam int CA_MODE_B = 4;   // bits 5:4 output action B
  localparam int CA_FORCE_A = 3;
  localparam int CA_FORCE_B = 2;
  localparam int CA_WAVE_LO = 0;  // bits 1:0 wave_mode_bit1:0
  localparam int CB_NOISE = 7;
  localparam int CB_EDGE = 6;
  localparam int CB_CMP_SRC = 5;
  localparam int CB_WAVE_HI = 3;  // bits 4:3 wave_mode_bit3:2
  localparam int CB_CS = 0;       // bits 2:0 clock_select_field
  localparam int FL_OVF = 0;
  localparam int FL_MATCH_B = 1;
  localparam int FL_MATCH_A = 2;
  localparam int FL_CAPT = 3;
  // ----------------------------------------
  // Reset values and fixed counts
  // ----------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam int NOISE_SAMPLES = 4;
  // ----------------------------------------
  // Clock select codes
  // ----------------------------------------
  localparam logic [2:0] CS_NONE = 3'h0;
  localparam logic [2:0] CS_DIRECT = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
endpackage

/* core/stc_clksel.sv */
// Clock select stage: turns the chosen source into one-cycle timer ticks.
// Assumes prescaler taps arrive as one-cycle pulses from a shared prescaler.
`timescale 1ns/100ps
module stc_clksel
  import stc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [2:0] clock_select_field,
  input wire logic [3:0] presc_tick,
  input wire logic ext_clock_pin,
  output logic timer_tick
);
  import stc_pkg::*;
  logic sync1_ff, sync2_ff, sync3_ff;
  logic ext_rise, ext_fall;

  // Two-stage synchroniser, third stage feeds the edge detector only
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
    end else begin
      sync1_ff <= ext_clock_pin;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end
  assign ext_rise = sync2_ff & ~sync3_ff;
  assign ext_fall = ~sync2_ff & sync3_ff;

  always_comb begin
    case (clock_select_field)
      CS_NONE: timer_tick = 1'b0;
      CS_DIRECT: timer_tick = 1'b1;
      CS_DIV8: timer_tick = presc_tick[0];
      CS_DIV64: timer_tick = presc_tick[1];
      CS_DIV256: timer_tick = presc_tick[2];
      CS_DIV1024: timer_tick = presc_tick[3];
      CS_EXT_FALL: timer_tick = ext_fall;
      CS_EXT_RISE: timer_tick = ext_rise;
      default: timer_tick = 1'b0;
    endcase
  end

  AST_EXT_RISE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clock_select_field == CS_EXT_RISE) |-> (timer_tick == (sync2_ff & ~sync3_ff)))
    else $error("external rising edge tick mismatch");
endmodule // stc_clksel

/* core/stc_capfilt.sv */
// Capture trigger path: source select, optional noise canceller, edge pick.
// Assumes the comparator output is already synchronous to clk_sys.
`timescale 1ns/100ps
module stc_capfilt
  import stc_pkg::*;
#(
  parameter int SAMPLES = NOISE_SAMPLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic capture_input_pin,
  input wire logic comparator_out,
  input wire logic use_comparator,
  input wire logic noise_enable,
  input wire logic rising_edge,
  output logic capture_event
);
  import stc_pkg::*;
  logic sync1_ff, sync2_ff;
  logic [SAMPLES-1:0] hist_ff;
  logic filt_ff, prev_ff;
  logic src, nxt_filt;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= capture_input_pin;
      sync2_ff <= sync1_ff;
    end
  end

  assign src = use_comparator ? comparator_out : sync2_ff;
  // Filter costs SAMPLES cycles of latency in exchange for spike rejection
  assign nxt_filt = !noise_enable ? src :
                    (&hist_ff) ? 1'b1 : (~|hist_ff) ? 1'b0 : filt_ff;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hist_ff <= '0;
      filt_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      hist_ff <= {hist_ff[SAMPLES-2:0], src};
      filt_ff <= nxt_filt;
      prev_ff <= filt_ff;
    end
  end
  assign capture_event = rising_edge ? (filt_ff & ~prev_ff) : (~filt_ff & prev_ff);

  AST_NOISE_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (noise_enable && !(&hist_ff) && |hist_ff) |=> (filt_ff == $past(filt_ff)))
    else $error("noise canceller passed a short spike");
endmodule // stc_capfilt

/* core/stc_timer.sv */
// Sixteen-bit timer/counter with two compare channels and one capture channel.
// Assumes APB master, shared prescaler taps and comparator outside this block.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module stc_timer
  import stc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] presc_tick,
  input wire logic ext_clock_pin,
  input wire logic capture_input_pin,
  input wire logic comparator_out,
  input wire logic [3:0] irq_ack,
  output logic [3:0] irq_req,
  output logic compare_out_a,
  output logic compare_out_a_oe,
  output logic compare_out_b,
  output logic compare_out_b_oe
);
  import stc_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  typedef enum {WAVE_PLAIN, WAVE_FAST, WAVE_DUAL} stc_wclass_t;

  function automatic stc_wclass_t wave_class(input logic [3:0] m);
    case (m)
      4'd0, 4'd4, 4'd12, 4'd13: wave_class = WAVE_PLAIN;
      4'd5, 4'd6, 4'd7, 4'd14, 4'd15: wave_class = WAVE_FAST;
      default: wave_class = WAVE_DUAL;
    endcase
  endfunction

  function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] ra,
                                         input logic [15:0] rc);
    case (m)
      4'd1, 4'd5: top_of = TOP_8BIT;
      4'd2, 4'd6: top_of = TOP_9BIT;
      4'd3, 4'd7: top_of = TOP_10BIT;
      4'd4, 4'd9, 4'd11, 4'd15: top_of = ra;
      4'd8, 4'd10, 4'd12, 4'd14: top_of = rc;
      default: top_of = CNT_MAX;
    endcase
  endfunction

  // Next compare pin level for one channel
  function automatic logic wave_next(input stc_wclass_t c, input logic [1:0] act,
                                     input logic cur, input logic hit, input logic top,
                                     input logic up, input logic tog_ok);
    logic lvl;
    lvl = (act == 2'd3);
    wave_next = cur;
    case (c)
      WAVE_PLAIN: begin
        if (hit) begin
          wave_next = (act == 2'd1) ? ~cur : lvl;
        end
      end
      WAVE_FAST: begin
        if (act == 2'd1) begin
          wave_next = (hit && tog_ok) ? ~cur : cur;
        end else if (hit) begin
          wave_next = lvl;
        end else if (top) begin
          wave_next = ~lvl;
        end
      end
      default: begin
        if (act == 2'd1) begin
          wave_next = (hit && tog_ok) ? ~cur : cur;
        end else if (hit) begin
          wave_next = up ? lvl : ~lvl;
        end
      end
    endcase
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] ctrl_a_ff, ctrl_b_ff, mask_ff, temp_ff;
  logic [3:0] flag_ff;
  logic [15:0] cnt_ff, ocra_buf_ff, ocra_act_ff, ocrb_buf_ff, ocrb_act_ff, icr_ff;
  logic up_ff, out_a_ff, out_b_ff;
  logic [31:0] prdata_ff;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire logic [3:0] wave_mode = {ctrl_b_ff[CB_WAVE_HI+1:CB_WAVE_HI],
                                ctrl_a_ff[CA_WAVE_LO+1:CA_WAVE_LO]};
  stc_wclass_t wclass;
  assign wclass = wave_class(wave_mode);
  wire logic [1:0] act_a = ctrl_a_ff[CA_MODE_A+1:CA_MODE_A];
  wire logic [1:0] act_b = ctrl_a_ff[CA_MODE_B+1:CA_MODE_B];
  wire logic [15:0] top_val = top_of(wave_mode, ocra_act_ff, icr_ff);
  wire logic at_top = (cnt_ff == top_val);
  wire logic at_bot = (cnt_ff == CNT_BOTTOM);
  wire logic at_max = (cnt_ff == CNT_MAX);
  wire logic pfc = (wave_mode == 4'd8) || (wave_mode == 4'd9);
  wire logic a_is_top = (wave_mode == 4'd9) || (wave_mode == 4'd11) ||
                        (wave_mode == 4'd15) || (wave_mode == 4'd4);
  wire logic icr_is_top = (wave_mode == 4'd8) || (wave_mode == 4'd10) ||
                          (wave_mode == 4'd12) || (wave_mode == 4'd14);
  wire logic a_pwm_off = a_is_top && (wclass != WAVE_PLAIN);

  wire logic acc = psel & penable;
  wire logic wr = acc & pwrite;
  wire logic rd = acc & ~pwrite;
  // Temp latches in the same cycle as the low byte, so a running count reads whole
  wire logic rd_setup = psel & ~penable & ~pwrite;
  wire logic [7:0] wbyte = pwdata[7:0];
  wire logic mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_MASK);
  wire logic wr_cnt = wr && (paddr == OFS_CNT_LO);
  wire logic wr_cmpa = wr && (paddr == OFS_CMPA_LO);
  wire logic wr_cmpb = wr && (paddr == OFS_CMPB_LO);
  wire logic wr_icr = wr && (paddr == OFS_CAP_LO);
  wire logic [15:0] wword = {temp_ff, wbyte};
  wire logic hi_wr = wr && (paddr == OFS_CNT_HI || paddr == OFS_CMPA_HI ||
                            paddr == OFS_CMPB_HI || paddr == OFS_CAP_HI);
  wire logic force_a = wr && (paddr == OFS_CTRL_A) && wbyte[CA_FORCE_A] &&
                       (wclass == WAVE_PLAIN);
  wire logic force_b = wr && (paddr == OFS_CTRL_A) && wbyte[CA_FORCE_B] &&
                       (wclass == WAVE_PLAIN);

  // ----------------------------------------
  // Clock select and capture trigger
  // ----------------------------------------
  logic timer_tick, cap_evt;

  stc_clksel u_clksel (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clock_select_field(ctrl_b_ff[CB_CS+2:CB_CS]),
    .presc_tick(presc_tick),
    .ext_clock_pin(ext_clock_pin),
    .timer_tick(timer_tick)
  );

  stc_capfilt #(.SAMPLES(NOISE_SAMPLES)) u_capfilt (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .capture_input_pin(capture_input_pin),
    .comparator_out(comparator_out),
    .use_comparator(ctrl_b_ff[CB_CMP_SRC]),
    .noise_enable(ctrl_b_ff[CB_NOISE]),
    .rising_edge(ctrl_b_ff[CB_EDGE]),
    .capture_event(cap_evt)
  );

  // ----------------------------------------
  // Count sequence
  // ----------------------------------------
  wire logic hit_a = timer_tick && (cnt_ff == ocra_act_ff);
  wire logic hit_b = timer_tick && (cnt_ff == ocrb_act_ff);
  wire logic do_cap = cap_evt && !icr_is_top;
  wire logic ovf_evt = timer_tick && ((wclass == WAVE_DUAL) ? at_bot :
                       (wave_mode == 4'd0) ? at_max : at_top);
  wire logic buf_load = (wclass == WAVE_PLAIN) ||
                        (timer_tick && (pfc ? at_bot : at_top));
  logic [15:0] nxt_cnt;
  logic nxt_up;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_up = up_ff;
    if (wr_cnt) begin
      nxt_cnt = wword;
    end else if (timer_tick) begin
      if (wclass == WAVE_DUAL) begin
        if (up_ff && at_top) begin
          nxt_up = 1'b0;
          nxt_cnt = cnt_ff - 16'h0001;
        end else if (!up_ff && at_bot) begin
          nxt_up = 1'b1;
          nxt_cnt = cnt_ff + 16'h0001;
        end else begin
          nxt_cnt = up_ff ? cnt_ff + 16'h0001 : cnt_ff - 16'h0001;
        end
      end else if (at_top && wave_mode != 4'd0) begin
        nxt_cnt = CNT_BOTTOM;
      end else begin
        nxt_cnt = cnt_ff + 16'h0001;                   // wraps at max
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= RST_WORD;
      up_ff <= 1'b1;
    end else begin
      cnt_ff <= nxt_cnt;
      up_ff <= nxt_up;
    end
  end

  // ----------------------------------------
  // Compare, capture and waveform
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ocra_buf_ff <= RST_WORD;
      ocrb_buf_ff <= RST_WORD;
      ocra_act_ff <= RST_WORD;
      ocrb_act_ff <= RST_WORD;
      icr_ff <= RST_WORD;
      out_a_ff <= 1'b0;
      out_b_ff <= 1'b0;
    end else begin
      ocra_buf_ff <= wr_cmpa ? wword : ocra_buf_ff;
      ocrb_buf_ff <= wr_cmpb ? wword : ocrb_buf_ff;
      // Plain modes copy through at once; PWM modes only at the update point
      ocra_act_ff <= buf_load ? (wr_cmpa ? wword : ocra_buf_ff) : ocra_act_ff;
      ocrb_act_ff <= buf_load ? (wr_cmpb ? wword : ocrb_buf_ff) : ocrb_act_ff;
      icr_ff <= wr_icr ? wword : (do_cap ? cnt_ff : icr_ff);
      out_a_ff <= wave_next(wclass, act_a, out_a_ff, hit_a | force_a,
                            timer_tick & at_top, up_ff, a_is_top);
      out_b_ff <= wave_next(wclass, act_b, out_b_ff, hit_b | force_b,
                            timer_tick & at_top, up_ff, 1'b0);
    end
  end

  assign compare_out_a = out_a_ff;
  assign compare_out_b = out_b_ff;
  // Toggle on match is the only action left when A sets the top in a PWM mode
  assign compare_out_a_oe = (act_a != 2'd0) && !(a_pwm_off && act_a != 2'd1);
  assign compare_out_b_oe = (act_b != 2'd0);

  // ----------------------------------------
  // Flags and masks
  // ----------------------------------------
  wire logic [3:0] flag_set = {do_cap, hit_a, hit_b, ovf_evt};
  wire logic [3:0] flag_clr = irq_ack |
                              ((wr && paddr == OFS_FLAG) ? wbyte[3:0] : 4'h0);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flag_ff <= 4'h0;
    end else begin
      flag_ff <= flag_set | (flag_ff & ~flag_clr);  // Set wins over clear
    end
  end
  assign irq_req = flag_ff & mask_ff[3:0];

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic [31:0] rd_mux;

  // Read data sampled in setup so the access phase answers from a flop
  always_comb begin
    case (paddr)
      OFS_CTRL_A: rd_mux = {24'h000000, ctrl_a_ff};
      OFS_CTRL_B: rd_mux = {24'h000000, ctrl_b_ff};
      OFS_CNT_LO: rd_mux = {24'h000000, cnt_ff[7:0]};
      OFS_CNT_HI: rd_mux = {24'h000000, temp_ff};
      OFS_CMPA_LO: rd_mux = {24'h000000, ocra_buf_ff[7:0]};
      OFS_CMPA_HI: rd_mux = {24'h000000, ocra_buf_ff[15:8]};
      OFS_CMPB_LO: rd_mux = {24'h000000, ocrb_buf_ff[7:0]};
      OFS_CMPB_HI: rd_mux = {24'h000000, ocrb_buf_ff[15:8]};
      OFS_CAP_LO: rd_mux = {24'h000000, icr_ff[7:0]};
      OFS_CAP_HI: rd_mux = {24'h000000, temp_ff};
      OFS_FLAG: rd_mux = {28'h0000000, flag_ff};
      OFS_MASK: rd_mux = {24'h000000, mask_ff};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_a_ff <= RST_BYTE;
      ctrl_b_ff <= RST_BYTE;
      mask_ff <= RST_BYTE;
      temp_ff <= RST_BYTE;
      prdata_ff <= 32'h00000000;
    end else begin
      // Force bits are strobes and never stored
      if (wr && paddr == OFS_CTRL_A) ctrl_a_ff <= wbyte & 8'hf3;
      if (wr && paddr == OFS_CTRL_B) ctrl_b_ff <= wbyte & 8'hff;
      if (wr && paddr == OFS_MASK) mask_ff <= wbyte & 8'h0f;
      if (hi_wr) begin
        temp_ff <= wbyte;
      end else if (rd_setup && paddr == OFS_CNT_LO) begin
        temp_ff <= cnt_ff[15:8];
      end else if (rd_setup && paddr == OFS_CAP_LO) begin
        temp_ff <= icr_ff[15:8];
      end
      if (psel && !penable) prdata_ff <= rd_mux;
    end
  end

  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  AST_BOTTOM_OVF: assert property ((wclass == WAVE_DUAL) && timer_tick && at_bot
    |=> flag_ff[FL_OVF]) else $error("bottom in dual slope did not flag overflow");
  AST_MAX_WRAP: assert property ((wave_mode == 4'd0) && timer_tick && at_max && !wr_cnt
    |=> cnt_ff == CNT_BOTTOM && flag_ff[FL_OVF]) else $error("max did not wrap");
  AST_HOLD_NO_CLK: assert property ((ctrl_b_ff[2:0] == CS_NONE) && !wr_cnt
    |=> cnt_ff == $past(cnt_ff)) else $error("counter moved without clock");
  AST_MATCH_A: assert property (timer_tick && cnt_ff == ocra_act_ff
    |=> flag_ff[FL_MATCH_A]) else $error("match A not flagged");
  AST_CAPTURE: assert property (cap_evt && !icr_is_top && !wr_icr
    |=> icr_ff == $past(cnt_ff) && flag_ff[FL_CAPT]) else $error("capture lost");
  AST_CTC_RELOAD: assert property (wave_mode == 4'd4 && timer_tick && at_top && !wr_cnt
    |=> cnt_ff == CNT_BOTTOM) else $error("clear on match failed");
  AST_WR16: assert property (wr && paddr == OFS_CNT_HI ##3 wr_cnt
    |=> cnt_ff == {$past(pwdata[7:0], 4), $past(pwdata[7:0])})
    else $error("16-bit write not joined");
  AST_CMP_HI: assert property (psel && !penable && paddr == OFS_CMPA_HI
    |=> prdata_ff[7:0] == $past(ocra_buf_ff[15:8])) else $error("compare high read");
  AST_IRQ_GATE: assert property (flag_ff[FL_CAPT] && mask_ff[FL_CAPT]
    |-> irq_req[FL_CAPT]) else $error("masked request missing");
  AST_A_PWM_OFF: assert property (a_pwm_off && act_a[1] |-> !compare_out_a_oe)
    else $error("A drives PWM while A is top");
  AST_SET_WINS: assert property (irq_ack[FL_OVF] && ovf_evt |=> flag_ff[FL_OVF])
    else $error("overflow lost on clear");

  CV_OVF: cover property (ovf_evt);
  CV_CAPTURE: cover property (do_cap);
  CV_CTC: cover property (wave_mode == 4'd4 && timer_tick && at_top);
  CV_DUAL_TURN: cover property (wclass == WAVE_DUAL && timer_tick && up_ff && at_top);
endmodule // stc_timer

/* tb/stc_host.sv */
// APB master model of the host core; byte registers on a 32-bit bus.
// Assumes the timer's clk_sys; waits are bounded and misses land in hang.
`timescale 1ns/100ps
module stc_host (
  input wire logic clk_sys,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [7:0] paddr = 8'h00,
  output logic [31:0] pwdata = 32'h0,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  int hang = 0;
  logic err;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (pready !== 1'b1 && i < 100);
    // Answer taken at the edge that sees pready high, then released
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      hang++;
      stc_timer_tb_top.end_sim();
    end
  endtask
  task automatic w16(input logic [7:0] a, input logic [15:0] v);
    logic [7:0] q;
    xfer(1'b1, a + 8'h04, v[15:8], q);
    xfer(1'b1, a, v[7:0], q);
  endtask
  task automatic r16(input logic [7:0] a, output logic [15:0] v);
    xfer(1'b0, a, 8'h00, v[7:0]);
    xfer(1'b0, a + 8'h04, 8'h00, v[15:8]);
  endtask
endmodule  // stc_host

/* tb/stc_timer_tb_top.sv */
// Self-checking bench: registers, clock select, flags and capture.
// Assumes stc_host on the APB side; the bench drives the timer pins.
`timescale 1ns/100ps
module stc_timer_tb_top;
  import stc_pkg::*;
  logic clk_sys = 1'b0, reset_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, ext_clock_pin = 1'b0;
  logic compare_out_a, compare_out_a_oe, compare_out_b, compare_out_b_oe;
  logic capture_input_pin = 1'b0, comparator_out = 1'b0;
  logic [7:0] paddr, q;
  logic [31:0] pwdata, prdata;
  logic [3:0] presc_tick = 4'h0, irq_ack = 4'h0, irq_req;
  logic [15:0] v, w;
  int errors = 0, n_compared = 0, n, k;
`define CHK(nm, e, s) begin \
  n_compared++; \
  if ((s) !== (e)) errors++; \
  if ((s) !== (e)) $display("[FAIL] %s expected %0h seen %0h", nm, e, s); \
end
  initial forever #2 clk_sys = ~clk_sys;
  stc_timer DUT (.clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .presc_tick, .ext_clock_pin, .capture_input_pin, .comparator_out,
    .irq_ack, .irq_req, .compare_out_a, .compare_out_a_oe, .compare_out_b, .compare_out_b_oe);
  stc_host u_host (.clk_sys, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);
  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, errors + u_host.hang);
    if (errors + u_host.hang == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    $display("[FAIL] run time expected finished seen timeout");
    end_sim();
  end
  initial begin
    n = $urandom(12);
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    u_host.xfer(1'b0, 8'h30, 8'h00, q);
    `CHK("unmapped", 1'b1, u_host.err)
    v = 16'($urandom);
    u_host.w16(OFS_CNT_LO, v);
    u_host.w16(OFS_CMPA_LO, ~v);
    u_host.r16(OFS_CNT_LO, w);
    `CHK("count", v, w)
    u_host.xfer(1'b1, OFS_CNT_HI, 8'h5a, q);
    u_host.xfer(1'b0, OFS_CMPA_HI, 8'h00, q);
    `CHK("cmp_a hi", ~v[15:8], q)
    // Taps 2..5 and pin edges 6/7; the pin toggles in tap runs, all four taps pulse in pin runs
    for (k = 2; k < 8; k++) begin
      n = 2 * (1 + $urandom % 3);
      u_host.w16(OFS_CNT_LO, 16'h0000);
      u_host.xfer(1'b1, OFS_CTRL_B, 8'(k), q);
      repeat (n) begin
        presc_tick <= (k < 6) ? 4'h1 << (k - 2) : 4'hf;
        ext_clock_pin <= ~ext_clock_pin;
        @(posedge clk_sys) presc_tick <= 4'h0;
        repeat (6) @(posedge clk_sys);
      end
      u_host.xfer(1'b1, OFS_CTRL_B, 8'h00, q);
      u_host.r16(OFS_CNT_LO, w);
      `CHK("ticks", 16'(k < 6 ? n : n / 2), w)
    end
    $display("registers and clock select done");
    u_host.xfer(1'b1, OFS_MASK, 8'h01 << FL_OVF, q);
    u_host.w16(OFS_CNT_LO, CNT_MAX - 16'h0002);
    u_host.xfer(1'b1, OFS_CTRL_B, 8'(CS_DIRECT), q);
    // Acknowledge held across the wrap: the set must beat the clear
    irq_ack <= 4'h1 << FL_OVF;
    repeat (3) @(posedge clk_sys);
    irq_ack <= 4'h0;
    u_host.xfer(1'b0, OFS_FLAG, 8'h00, q);
    `CHK("overflow", 1'b1, q[FL_OVF])
    `CHK("irq ovf", 1'b1, irq_req[FL_OVF])
    n = 3 + $urandom % 5;
    u_host.w16(OFS_CMPA_LO, 16'(n));
    u_host.xfer(1'b1, OFS_CTRL_A, 8'h40, q);
    u_host.xfer(1'b1, OFS_CTRL_B, 8'h09, q);
    u_host.w16(OFS_CNT_LO, CNT_BOTTOM);
    u_host.xfer(1'b1, OFS_FLAG, 8'h0f, q);
    repeat (40) @(posedge clk_sys);
    u_host.xfer(1'b1, OFS_CTRL_B, 8'h08, q);
    u_host.r16(OFS_CNT_LO, w);
    // 46 ticks from the count write to the stop; one toggle per match
    `CHK("ctc count", 16'(46 % (n + 1)), w)
    `CHK("out a", 1'((46 / (n + 1)) % 2), compare_out_a)
    `CHK("oe a", 1'b1, compare_out_a_oe)
    `CHK("out b", 1'b0, compare_out_b)
    `CHK("oe b", 1'b0, compare_out_b_oe)
    u_host.xfer(1'b0, OFS_FLAG, 8'h00, q);
    `CHK("match a", 1'b1, q[FL_MATCH_A])
    `CHK("masked", 1'b0, irq_req[FL_MATCH_A])
    u_host.xfer(1'b1, OFS_FLAG, 8'h01 << FL_OVF, q);
    u_host.xfer(1'b0, OFS_FLAG, 8'h00, q);
    `CHK("ovf cleared", 1'b0, q[FL_OVF])
    `CHK("a kept", 1'b1, q[FL_MATCH_A])
    v = 16'($urandom);
    u_host.xfer(1'b1, OFS_CTRL_B, 8'hc0, q);
    u_host.xfer(1'b0, OFS_CTRL_B, 8'h00, q);
    `CHK("ctrl_b", 8'hc0, q)
    u_host.w16(OFS_CNT_LO, v);
    capture_input_pin <= 1'b1;
    @(posedge clk_sys) capture_input_pin <= 1'b0;
    repeat (10) @(posedge clk_sys);
    u_host.r16(OFS_CAP_LO, w);
    `CHK("spike", RST_WORD, w)
    capture_input_pin <= 1'b1;
    repeat (10) @(posedge clk_sys);
    u_host.r16(OFS_CAP_LO, w);
    `CHK("capture", v, w)
    u_host.xfer(1'b0, OFS_FLAG, 8'h00, q);
    `CHK("capt flag", 1'b1, q[FL_CAPT])
    irq_ack <= 4'h1 << FL_CAPT;
    @(posedge clk_sys) irq_ack <= 4'h0;
    u_host.xfer(1'b0, OFS_FLAG, 8'h00, q);
    `CHK("capt serviced", 1'b0, q[FL_CAPT])
    u_host.xfer(1'b1, OFS_CTRL_B, 8'h20, q);
    u_host.w16(OFS_CNT_LO, ~v);
    comparator_out <= 1'b1;
    repeat (3) @(posedge clk_sys);
    comparator_out <= 1'b0;
    repeat (4) @(posedge clk_sys);
    u_host.r16(OFS_CAP_LO, w);
    `CHK("comparator", ~v, w)
    $display("flags and capture done");
    u_host.xfer(1'b1, OFS_CTRL_A, 8'h01, q);
    u_host.w16(OFS_CNT_LO, CNT_BOTTOM);
    u_host.xfer(1'b1, OFS_FLAG, 8'h0f, q);
    u_host.xfer(1'b1, OFS_CTRL_B, 8'(CS_DIRECT), q);
    repeat (300) @(posedge clk_sys);
    u_host.xfer(1'b1, OFS_CTRL_B, 8'h00, q);
    u_host.r16(OFS_CNT_LO, w);
    // 303 ticks: up to the 8-bit top, then back down
    `CHK("dual count", 16'h00cf, w)
    u_host.xfer(1'b0, OFS_FLAG, 8'h00, q);
    `CHK("bottom ovf", 1'b1, q[FL_OVF])
    $display("dual slope done");
    end_sim();
  end
endmodule  // stc_timer_tb_top
